//--- common/frps_pkg.sv
//------------------------------------------------------------
// constants of the row program sequencer
//------------------------------------------------------------
// Overview of operation
// - flash programmed only in eight-byte blocks
// - eight holding bytes, one per table write
// - table write touches only one holding byte
// - control write launches long write of block
// - processor stalled for whole long write
// - internal timer of about 2 ms ends write
// - holding bytes return to FFh after reset/write
// - holding byte FFh leaves flash byte unchanged
// - programming only clears bits one to zero
// - partial load of holding bytes is allowed
// - general update reads, erases, then reprograms
// - load bytes with auto-incrementing pointer writes
// - select program space, permit writes before start
// - start accepted only right after 55h, 0AAh
// - start bit after unlock begins write cycle
// - pointer stays inside block before start (host pointer is not bounded; auto-increment runs past the block end)
// - whole row update budget about 6 ms
// - verify row afterwards by reading it back
// - start refused while write permit is clear
// - hardware clears start bit on completion
// - reset during write sets aborted flag (rst_n only; a power-on reset clears it)
// - done flag set on completion, software clears
package frps_pkg;

	//------------------------------------------------------------
	// widths
	//------------------------------------------------------------
	localparam int HOLD_N = 8;
	localparam int FLASH_BLOCKS = 16;

	//------------------------------------------------------------
	// unlock keys and reset values
	//------------------------------------------------------------
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam logic [7:0] HOLD_RESET = 8'hFF;
	localparam logic [63:0] BLOCK_ERASED = 64'hFFFF_FFFF_FFFF_FFFF;
	localparam logic [21:0] PTR_RESET = 22'h00_0000;

	//------------------------------------------------------------
	// memory control register bit positions
	//------------------------------------------------------------
	localparam int CTRL_PROG_SEL = 7;
	localparam int CTRL_CFG_SEL = 6;
	localparam int CTRL_ABORT = 3;
	localparam int CTRL_PERMIT = 2;
	localparam int CTRL_START = 1;

	//------------------------------------------------------------
	// timing
	//------------------------------------------------------------
	localparam int CLK_FREQ_HZ = 25_000_000;
	localparam int PROG_TIME_US = 2000;
	localparam int PROG_CYCLES = PROG_TIME_US * (CLK_FREQ_HZ / 1_000_000);

	//------------------------------------------------------------
	// controller registers on the bus
	//------------------------------------------------------------
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_PTR = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam int CMD_OP_LSB = 8;
	localparam int CMD_AUTOINC = 10;
	localparam int STAT_STALL = 8;
	localparam int STAT_DONE = 9;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// command kinds
	typedef enum logic [1:0] {OP_NONE, OP_TABLE, OP_CTRL, OP_KEY} frps_op_e;

	// sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_COMMIT} frps_state_e;

endpackage : frps_pkg

//--- common/frps_if.sv
`timescale 1ns/1ns
// link between processor and flash sequencer
interface frps_if;
	// table write: strobe, pointer, latch byte
	logic tblWrStb;
	logic [21:0] tableTointer;
	logic [7:0] tableLatch;
	// memory control register write and its read-back
	logic ctrlWrStb;
	logic [7:0] ctrlWrData;
	logic [7:0] memoryControlReg;
	// unlock key register write
	logic keyWrStb;
	logic [7:0] keyWrData;
	// completion and stall
	logic programDoneFlag;
	logic doneClrStb;
	logic stall;

	modport dev (
		input tblWrStb, tableTointer, tableLatch, ctrlWrStb, ctrlWrData,
		input keyWrStb, keyWrData, doneClrStb,
		output memoryControlReg, programDoneFlag, stall
	);
	modport cpu (
		output tblWrStb, tableTointer, tableLatch, ctrlWrStb, ctrlWrData,
		output keyWrStb, keyWrData, doneClrStb,
		input memoryControlReg, programDoneFlag, stall
	);
endinterface : frps_if

//--- logic/frps_hold_regs.sv
`timescale 1ns/1ns
// eight byte-wide holding registers filled by table writes
module frps_hold_regs (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// byte load
	input wire logic erase_program_permit,
	input wire logic [2:0] wrIdx,
	input wire logic [7:0] wrData,
	// return all bytes to erased value
	input wire logic clrAll,
	// all eight bytes, byte 0 lowest
	output logic [63:0] holdVec
);
	logic [7:0] holdQ [8];

	//------------------------------------------------------------
	// storage
	//------------------------------------------------------------
	// clear beats load, so a stray write at commit is dropped
	always_ff @(posedge ref_clk) begin
		if (!rst_n || clrAll) begin
			for (int i = 0; i < frps_pkg::HOLD_N; i++) begin
				holdQ[i] <= frps_pkg::HOLD_RESET;
			end
		end else if (erase_program_permit) begin
			holdQ[wrIdx] <= wrData;
		end
	end

	// flatten for the commit logic
	always_comb begin
		for (int i = 0; i < frps_pkg::HOLD_N; i++) begin
			holdVec[i*8 +: 8] = holdQ[i];
		end
	end
endmodule : frps_hold_regs

//--- logic/frps_device.sv
`timescale 1ns/1ns
// flash row program sequencer, device end
module frps_device #(
	parameter int PROG_CYCLES = frps_pkg::PROG_CYCLES
) (
	// clock and resets
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic porRst_n,
	// link to processor
	frps_if.dev lnk,
	// row erase and read-back of the array
	input wire logic eraseStb,
	input wire logic [3:0] eraseIdx,
	input wire logic [21:0] rdAddr,
	output logic [7:0] rdData
);
	//------------------------------------------------------------
	// declarations
	//------------------------------------------------------------
	frps_pkg::frps_state_e stateQ; // sequencer state
	logic [31:0] timerQ; // programming timer, counts down
	logic [1:0] keyStepQ; // 0 none, 1 first key, 2 unlocked
	logic progSelQ; // program space select
	logic cfgSelQ; // configuration space select
	logic permitQ; // erase/program permit
	logic startQ; // program start bit
	logic abortQ; // aborted program flag
	logic doneQ; // program done flag
	logic stallQ; // processor stall
	logic [7:0] ctrlRdQ; // read-back of control register
	logic [7:0] rdDataQ; // read-back byte
	logic [18:0] blkQ; // block chosen at start
	logic [63:0] holdVec; // holding bytes
	logic [63:0] flashMem [16]; // program array, one block per word
	logic startOk; // start accepted this cycle
	logic commit; // write ends this cycle
	logic busy; // long write in progress

	//------------------------------------------------------------
	// helpers
	//------------------------------------------------------------
	// a held FFh keeps the byte; otherwise bits only fall
	function automatic logic [63:0] mergeBlock(
		input logic [63:0] old,
		input logic [63:0] hold
	);
		logic [63:0] res;
		res = old;
		for (int i = 0; i < 8; i++) begin
			if (hold[i*8 +: 8] != frps_pkg::HOLD_RESET) begin
				res[i*8 +: 8] = old[i*8 +: 8] & hold[i*8 +: 8];
			end
		end
		return res;
	endfunction : mergeBlock

	// block index within the small array
	function automatic logic [3:0] blkIdx(input logic [18:0] blk);
		return blk[3:0];
	endfunction : blkIdx

	assign busy = (stateQ != frps_pkg::ST_IDLE);
	assign commit = (stateQ == frps_pkg::ST_COMMIT);

	// start needs unlock, permit and program space
	assign startOk = lnk.ctrlWrStb && !busy
		&& lnk.ctrlWrData[frps_pkg::CTRL_START]
		&& (keyStepQ == 2'h2)
		&& permitQ
		&& progSelQ && !cfgSelQ;

	//------------------------------------------------------------
	// holding registers
	//------------------------------------------------------------
	frps_hold_regs u_hold (
		.ref_clk(ref_clk),
		.rst_n(rst_n && porRst_n),
		.erase_program_permit(lnk.tblWrStb && !busy),
		.wrIdx(lnk.tableTointer[2:0]),
		.wrData(lnk.tableLatch),
		.clrAll(commit),
		.holdVec(holdVec)
	);

	//------------------------------------------------------------
	// unlock key sequence
	//------------------------------------------------------------
	// any table, control or key write between keys and start breaks it; a done clear does not
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !porRst_n) begin
			keyStepQ <= 2'h0;
		end else if (lnk.keyWrStb) begin
			if (lnk.keyWrData == frps_pkg::KEY_FIRST) begin
				keyStepQ <= 2'h1;
			end else if (keyStepQ == 2'h1
				&& lnk.keyWrData == frps_pkg::KEY_SECOND) begin
				keyStepQ <= 2'h2;
			end else begin
				keyStepQ <= 2'h0;
			end
		end else if (lnk.tblWrStb || lnk.ctrlWrStb) begin
			keyStepQ <= 2'h0;
		end
	end

	//------------------------------------------------------------
	// control register bits
	//------------------------------------------------------------
	// permit may change mid-write; the sequencer no longer reads it
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !porRst_n) begin
			progSelQ <= 1'b0;
			cfgSelQ <= 1'b0;
			permitQ <= 1'b0;
		end else if (lnk.ctrlWrStb) begin
			progSelQ <= lnk.ctrlWrData[frps_pkg::CTRL_PROG_SEL];
			cfgSelQ <= lnk.ctrlWrData[frps_pkg::CTRL_CFG_SEL];
			permitQ <= lnk.ctrlWrData[frps_pkg::CTRL_PERMIT];
		end
	end

	// start bit: software sets, hardware clears at the end
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !porRst_n) begin
			startQ <= 1'b0;
		end else if (startOk) begin
			startQ <= 1'b1;
		end else if (commit) begin
			startQ <= 1'b0;
		end
	end

	// abort flag kept over rst_n; power-on clears
	always_ff @(posedge ref_clk) begin
		if (!porRst_n) begin
			abortQ <= 1'b0;
		end else if (!rst_n) begin
			abortQ <= abortQ || busy;
		end else if (lnk.ctrlWrStb) begin
			abortQ <= lnk.ctrlWrData[frps_pkg::CTRL_ABORT];
		end
	end

	// done flag: completion wins over a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !porRst_n) begin
			doneQ <= 1'b0;
		end else if (commit) begin
			doneQ <= 1'b1;
		end else if (lnk.doneClrStb) begin
			doneQ <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// long write sequencer
	//------------------------------------------------------------
	// whole block only; there is no byte or word write path
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !porRst_n) begin
			stateQ <= frps_pkg::ST_IDLE;
			timerQ <= 32'h0000_0000;
			blkQ <= 19'h0_0000;
		end else begin
			case (stateQ)
				frps_pkg::ST_IDLE: begin
					if (startOk) begin
						stateQ <= frps_pkg::ST_WRITE;
						timerQ <= 32'(PROG_CYCLES - 2);
						blkQ <= lnk.tableTointer[21:3];
					end
				end
				frps_pkg::ST_WRITE: begin
					if (timerQ == 32'h0000_0000) begin
						stateQ <= frps_pkg::ST_COMMIT;
					end else begin
						timerQ <= timerQ - 32'h0000_0001;
					end
				end
				frps_pkg::ST_COMMIT: begin
					stateQ <= frps_pkg::ST_IDLE;
				end
				default: begin
					stateQ <= frps_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// stall from accepted start until the cycle after commit
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !porRst_n) begin
			stallQ <= 1'b0;
		end else if (startOk) begin
			stallQ <= 1'b1;
		end else if (commit) begin
			stallQ <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// program array
	//------------------------------------------------------------
	// erase and power-on reset are the only ways back to ones; an erase while busy is dropped
	always_ff @(posedge ref_clk) begin
		if (!porRst_n) begin
			for (int i = 0; i < frps_pkg::FLASH_BLOCKS; i++) begin
				flashMem[i] <= frps_pkg::BLOCK_ERASED;
			end
		end else if (commit) begin
			flashMem[blkIdx(blkQ)] <=
				mergeBlock(flashMem[blkIdx(blkQ)], holdVec);
		end else if (eraseStb && !busy) begin
			flashMem[eraseIdx] <= frps_pkg::BLOCK_ERASED;
		end
	end

	// read-back, one cycle latency
	always_ff @(posedge ref_clk) begin
		if (!porRst_n) begin
			rdDataQ <= 8'h00;
		end else begin
			rdDataQ <= flashMem[blkIdx(rdAddr[21:3])][rdAddr[2:0]*8 +: 8];
		end
	end

	//------------------------------------------------------------
	// register read-back and outputs
	//------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!porRst_n) begin
			ctrlRdQ <= 8'h00;
		end else begin
			ctrlRdQ <= {progSelQ, cfgSelQ, 2'h0, abortQ, permitQ, startQ, 1'b0};
		end
	end

	assign lnk.memoryControlReg = ctrlRdQ;
	assign lnk.programDoneFlag = doneQ;
	assign lnk.stall = stallQ;
	assign rdData = rdDataQ;
endmodule : frps_device

//--- logic/frps_host.sv
`timescale 1ns/1ns
// processor end: bus registers turned into link writes
module frps_host (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// link to device
	frps_if.cpu lnk
);
	logic awReadyQ, wReadyQ, bValidQ, arReadyQ, rValidQ;
	logic [7:0] awAddrQ;
	logic [31:0] wDataQ, rDataQ;
	logic [1:0] bRespQ, rRespQ;
	logic [21:0] ptrQ; // table pointer
	logic incQ; // post-increment pending
	logic tblQ, ctrlQ, keyQ, clrQ; // one-cycle link strobes
	logic [7:0] byteQ; // data of the strobe
	logic exec; // both halves held, device free
	frps_pkg::frps_op_e op;

	assign op = frps_pkg::frps_op_e'(wDataQ[frps_pkg::CMD_OP_LSB +: 2]);
	// writes wait while the device stalls the processor
	assign exec = !awReadyQ && !wReadyQ && !bValidQ && !lnk.stall;

	//------------------------------------------------------------
	// write channels
	//------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			awReadyQ <= 1'b1;
			wReadyQ <= 1'b1;
			bValidQ <= 1'b0;
			bRespQ <= frps_pkg::RESP_OKAY;
			awAddrQ <= 8'h00;
			wDataQ <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && awReadyQ) begin
				awReadyQ <= 1'b0;
				awAddrQ <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wReadyQ) begin
				wReadyQ <= 1'b0;
				wDataQ <= s_axi_wdata;
			end
			if (exec) begin
				bValidQ <= 1'b1;
				bRespQ <= (awAddrQ == frps_pkg::REG_CMD
					|| awAddrQ == frps_pkg::REG_PTR
					|| awAddrQ == frps_pkg::REG_STAT)
					? frps_pkg::RESP_OKAY : frps_pkg::RESP_SLVERR;
			end else if (bValidQ && s_axi_bready) begin
				bValidQ <= 1'b0;
				awReadyQ <= 1'b1;
				wReadyQ <= 1'b1;
			end
		end
	end

	//------------------------------------------------------------
	// link strobes and pointer
	//------------------------------------------------------------
	// keys and control bytes pass untouched; software owns order
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			{tblQ, ctrlQ, keyQ, clrQ, incQ} <= 5'h00;
			byteQ <= 8'h00;
			ptrQ <= frps_pkg::PTR_RESET;
		end else begin
			tblQ <= 1'b0;
			ctrlQ <= 1'b0;
			keyQ <= 1'b0;
			clrQ <= 1'b0;
			incQ <= 1'b0;
			if (incQ) begin
				ptrQ <= ptrQ + 22'h00_0001;
			end
			if (exec && awAddrQ == frps_pkg::REG_CMD) begin
				byteQ <= wDataQ[7:0];
				tblQ <= (op == frps_pkg::OP_TABLE);
				incQ <= (op == frps_pkg::OP_TABLE)
					&& wDataQ[frps_pkg::CMD_AUTOINC];
				ctrlQ <= (op == frps_pkg::OP_CTRL);
				keyQ <= (op == frps_pkg::OP_KEY);
			end else if (exec && awAddrQ == frps_pkg::REG_PTR) begin
				ptrQ <= wDataQ[21:0];
			end else if (exec && awAddrQ == frps_pkg::REG_STAT) begin
				clrQ <= wDataQ[frps_pkg::STAT_DONE];
			end
		end
	end

	//------------------------------------------------------------
	// read channel
	//------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			arReadyQ <= 1'b1;
			rValidQ <= 1'b0;
			rDataQ <= 32'h0000_0000;
			rRespQ <= frps_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && arReadyQ) begin
			arReadyQ <= 1'b0;
			rValidQ <= 1'b1;
			rRespQ <= frps_pkg::RESP_OKAY;
			case (s_axi_araddr)
				frps_pkg::REG_CMD: rDataQ <= 32'h0000_0000;
				frps_pkg::REG_PTR: rDataQ <= {10'h000, ptrQ};
				frps_pkg::REG_STAT: rDataQ <= {22'h00_0000,
					lnk.programDoneFlag, lnk.stall, lnk.memoryControlReg};
				default: begin
					rDataQ <= 32'h0000_0000;
					rRespQ <= frps_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rValidQ && s_axi_rready) begin
			rValidQ <= 1'b0;
			arReadyQ <= 1'b1;
		end
	end

	assign s_axi_awready = awReadyQ;
	assign s_axi_wready = wReadyQ;
	assign s_axi_bvalid = bValidQ;
	assign s_axi_bresp = bRespQ;
	assign s_axi_arready = arReadyQ;
	assign s_axi_rvalid = rValidQ;
	assign s_axi_rdata = rDataQ;
	assign s_axi_rresp = rRespQ;
	assign lnk.tblWrStb = tblQ;
	assign lnk.tableTointer = ptrQ;
	assign lnk.tableLatch = byteQ;
	assign lnk.ctrlWrStb = ctrlQ;
	assign lnk.ctrlWrData = byteQ;
	assign lnk.keyWrStb = keyQ;
	assign lnk.keyWrData = byteQ;
	assign lnk.doneClrStb = clrQ;
endmodule : frps_host

//--- bench/frps_chk.sv
`timescale 1ns/1ns
//------------------------------------------------------------
// link checker
//------------------------------------------------------------
module frps_chk #(
	parameter int PROG_CYCLES = 20
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// link signals
	input wire logic tblWrStb,
	input wire logic ctrlWrStb,
	input wire logic [7:0] ctrlWrData,
	input wire logic keyWrStb,
	input wire logic [7:0] keyWrData,
	input wire logic [7:0] memoryControlReg,
	input wire logic programDoneFlag,
	input wire logic doneClrStb,
	input wire logic stall
);
	logic [1:0] unlockStep_q; // 1 after first key, 2 after second
	int stallCnt_q; // stall cycles seen so far

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// any table or control write breaks the key pair
	always_ff @(posedge ref_clk) begin
		if (!rst_n || tblWrStb || ctrlWrStb) begin
			unlockStep_q <= 2'h0;
		end else if (keyWrStb) begin
			// a wrong key drops back to the start
			unlockStep_q <= (keyWrData == frps_pkg::KEY_FIRST) ? 2'h1 :
				(keyWrData == frps_pkg::KEY_SECOND && unlockStep_q == 2'h1)
				? 2'h2 : 2'h0;
		end
	end

	// length of the current stall
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !stall) begin
			stallCnt_q <= 0;
		end else begin
			stallCnt_q <= stallCnt_q + 1;
		end
	end

	// unlocked start with stored permit, program space, idle
	sequence s_launch;
		ctrlWrStb && ctrlWrData[frps_pkg::CTRL_START] && unlockStep_q == 2'h2
		&& memoryControlReg[frps_pkg::CTRL_PERMIT] && !stall
		&& memoryControlReg[frps_pkg::CTRL_PROG_SEL]
		&& !memoryControlReg[frps_pkg::CTRL_CFG_SEL];
	endsequence
	// end of write: done, then start bit clear
	sequence s_finish;
		programDoneFlag ##1 !memoryControlReg[frps_pkg::CTRL_START];
	endsequence

	property p_launch;
		s_launch |=> stall;
	endproperty
	a_launch: assert property (p_launch)
		else $error("unlocked start did not stall");
	property p_no_key;
		ctrlWrStb && unlockStep_q != 2'h2 && !stall |=> !stall;
	endproperty
	a_no_key: assert property (p_no_key)
		else $error("start taken without key pair");
	property p_no_permit;
		ctrlWrStb && !memoryControlReg[frps_pkg::CTRL_PERMIT] && !stall
		|=> !stall;
	endproperty
	a_no_permit: assert property (p_no_permit)
		else $error("start taken without permit");
	property p_stall_cause;
		$rose(stall) |-> $past(ctrlWrStb) && $past(unlockStep_q) == 2'h2;
	endproperty
	a_stall_cause: assert property (p_stall_cause)
		else $error("stall without unlocked start");
	property p_stall_len;
		$fell(stall) && $past(rst_n) |-> stallCnt_q == PROG_CYCLES;
	endproperty
	a_stall_len: assert property (p_stall_len)
		else $error("long write length wrong");
	property p_stall_max;
		stallCnt_q <= PROG_CYCLES;
	endproperty
	a_stall_max: assert property (p_stall_max)
		else $error("stall too long");
	property p_finish;
		$fell(stall) && $past(rst_n) |-> s_finish;
	endproperty
	a_finish: assert property (p_finish)
		else $error("completion not flagged");
	property p_done_cause;
		$rose(programDoneFlag) |-> $fell(stall);
	endproperty
	a_done_cause: assert property (p_done_cause)
		else $error("done without completion");
	property p_done_sticky;
		programDoneFlag && !doneClrStb |=> programDoneFlag;
	endproperty
	a_done_sticky: assert property (p_done_sticky)
		else $error("done dropped by itself");
	property p_done_clear;
		doneClrStb && !stall |=> !programDoneFlag;
	endproperty
	a_done_clear: assert property (p_done_clear)
		else $error("done not cleared");
endmodule : frps_chk

//--- bench/flash_row_program_sequencer_test.sv
`timescale 1ns/1ns
// both ends joined, driven over the bus
module flash_row_program_sequencer_test;
	localparam int PROG_N = 20; // shortened long write
	localparam int LIMIT = 20000; // hang guard in cycles
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic porRst_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic eraseStb = 1'b0;
	logic [3:0] eraseIdx = 4'h0;
	logic [21:0] rdAddr = 22'h00_0000;
	logic [7:0] rdData;
	logic [7:0] flashMod [128]; // expected array contents
	int err_total = 0;
	int checks = 0;
	int cycles = 0;

	frps_if lnk();
	frps_host frps_host_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .lnk(lnk));
	frps_device #(.PROG_CYCLES(PROG_N)) frps_device_i (.ref_clk(ref_clk),
		.rst_n(rst_n), .porRst_n(porRst_n), .lnk(lnk), .eraseStb(eraseStb),
		.eraseIdx(eraseIdx), .rdAddr(rdAddr), .rdData(rdData));
	frps_chk #(.PROG_CYCLES(PROG_N)) frps_chk_i (.ref_clk(ref_clk),
		.rst_n(rst_n), .tblWrStb(lnk.tblWrStb), .ctrlWrStb(lnk.ctrlWrStb),
		.ctrlWrData(lnk.ctrlWrData), .keyWrStb(lnk.keyWrStb),
		.keyWrData(lnk.keyWrData), .memoryControlReg(lnk.memoryControlReg),
		.programDoneFlag(lnk.programDoneFlag), .doneClrStb(lnk.doneClrStb),
		.stall(lnk.stall));

	always #20 ref_clk = ~ref_clk;

	// hang guard: counts as a mismatch
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_total++;
			tally_and_finish();
		end
	end

	//------------------------------------------------------------
	// compare and bus tasks
	//------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
		chk({30'h0, got}, {30'h0, exp});
	endtask : chk_rsp
	// aw and w together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk_rsp(r, frps_pkg::RESP_OKAY);
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk_rsp(r, frps_pkg::RESP_OKAY);
		chk(d, exp);
	endtask : reg_rd
	task automatic cmd(input frps_pkg::frps_op_e op, input logic [7:0] b,
		input logic inc);
		reg_wr(frps_pkg::REG_CMD, {21'h0, inc, op, b});
	endtask : cmd
	// permit, key pair, start
	task automatic start_seq(input logic [7:0] pre, input logic [7:0] k1,
		input logic [7:0] k2, input logic [7:0] st);
		cmd(frps_pkg::OP_CTRL, pre, 1'b0);
		cmd(frps_pkg::OP_KEY, k1, 1'b0);
		cmd(frps_pkg::OP_KEY, k2, 1'b0);
		cmd(frps_pkg::OP_CTRL, st, 1'b0);
	endtask : start_seq
	// read back one block
	task automatic chk_block(input int blk);
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			rdAddr <= 22'(blk * 8 + i);
			repeat (2) @(posedge ref_clk);
			chk(32'(rdData), 32'(flashMod[blk * 8 + i]));
		end
	endtask : chk_block

	//------------------------------------------------------------
	// scenarios
	//------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		reg_rd(frps_pkg::REG_STAT, 32'h0000_0000);
		reg_rd(frps_pkg::REG_PTR, 32'h0000_0000);
		axi_wr(8'h0C, 32'h0000_0001, r);
		chk_rsp(r, frps_pkg::RESP_SLVERR);
		axi_rd(8'h0C, d, r);
		chk_rsp(r, frps_pkg::RESP_SLVERR);
		chk(d, 32'h0000_0000);
	endtask : t_reset
	// load bytes, then program
	task automatic t_program(input int blk, input logic [63:0] v,
		input logic [7:0] sel, input logic inc);
		if (inc) reg_wr(frps_pkg::REG_PTR, 32'(blk * 8));
		for (int i = 0; i < 8; i++) begin
			if (!inc && sel[i]) reg_wr(frps_pkg::REG_PTR, 32'(blk * 8 + i));
			if (sel[i]) cmd(frps_pkg::OP_TABLE, v[i * 8 +: 8], inc);
			// FFh leaves the array byte alone
			if (sel[i] && v[i * 8 +: 8] != 8'hFF)
				flashMod[blk * 8 + i] &= v[i * 8 +: 8];
		end
		if (inc) reg_rd(frps_pkg::REG_PTR, 32'(blk * 8 + 8));
		reg_wr(frps_pkg::REG_PTR, 32'(blk * 8));
		start_seq(8'h84, 8'h55, 8'hAA, 8'h86);
		// held off until stall ends
		reg_wr(frps_pkg::REG_PTR, 32'(blk * 8));
		reg_rd(frps_pkg::REG_STAT, 32'h0000_0284);
		reg_wr(frps_pkg::REG_STAT, 32'h0000_0200);
		reg_rd(frps_pkg::REG_STAT, 32'h0000_0084);
		chk_block(blk);
	endtask : t_program
	task automatic t_erase(input int blk);
		@(posedge ref_clk);
		eraseIdx <= 4'(blk);
		eraseStb <= 1'b1;
		@(posedge ref_clk);
		eraseStb <= 1'b0;
		for (int i = 0; i < 8; i++) flashMod[blk * 8 + i] = 8'hFF;
		chk_block(blk);
	endtask : t_erase
	// wrong key order, no permit, config space, bad key
	task automatic t_refuse();
		logic [7:0] tbl [4][4] = '{'{8'h84, 8'hAA, 8'h55, 8'h86},
			'{8'h80, 8'h55, 8'hAA, 8'h82}, '{8'hC4, 8'h55, 8'hAA, 8'hC6},
			'{8'h84, 8'h55, 8'h33, 8'h86}};
		for (int i = 0; i < 4; i++) begin
			start_seq(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3]);
			reg_rd(frps_pkg::REG_STAT, {24'h00_0000, tbl[i][0]});
		end
		chk_block(2);
	endtask : t_refuse
	// reset mid-write: flag set, array kept, holding bytes back to FFh
	task automatic t_abort();
		reg_wr(frps_pkg::REG_PTR, 32'h0000_0017);
		cmd(frps_pkg::OP_TABLE, 8'h00, 1'b0);
		start_seq(8'h84, 8'h55, 8'hAA, 8'h86);
		do @(posedge ref_clk); while (!lnk.stall);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		reg_rd(frps_pkg::REG_STAT, 32'h0000_0008);
		chk_block(2);
		// erased holding bytes change nothing
		t_program(2, 64'hFFFF_FFFF_FFFF_FFFF, 8'h00, 1'b0);
	endtask : t_abort

	task automatic tally_and_finish();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		for (int i = 0; i < 128; i++) flashMod[i] = 8'hFF;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		porRst_n <= 1'b1;
		t_reset();
		chk_block(2);
		t_program(2, 64'h0123_4567_FFAB_CDEF, 8'hFF, 1'b1);
		chk_block(3);
		t_erase(2);
		t_program(2, 64'hFFFF_FFFF_FFFF_FF1F, 8'h01, 1'b0);
		t_program(2, 64'hFFFF_FFFF_FFFF_FFF0, 8'h01, 1'b0);
		t_refuse();
		t_abort();
		tally_and_finish();
	end
endmodule : flash_row_program_sequencer_test
